// [logic/occ_cfg.svh]
// Constants for the oscillator control register block
// Operation
// - Bit 7 set inverts the chosen output clock
// - Low jitter edge: rising normally, falling inverted
// - Bit 5: 0 gives 24 hour, 1 gives 12 hour
// - Elapsed-time counter mode ignores the hour format
// - Bit 4 selects low jitter clock output
// - Drive bits: 00 normal, 01 low, 1x high
// - Load bits: 00 7.0pF, 01 6.0pF, 1x 12.5pF
// - Bit 6 selects the offset calibration mode
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH

// =====================================================
// Register address and reset value
`define OCC_OSC_CTRL_ADDR 8'h25
`define OCC_OSC_CTRL_RESET 8'h00
`define OCC_RDATA_UNMAPPED 8'h00

// =====================================================
// Field positions
`define OCC_BIT_INVERT 7
`define OCC_BIT_OFFSET_MODE 6
`define OCC_BIT_HOUR_FMT 5
`define OCC_BIT_LOW_JITTER 4
`define OCC_DRIVE_HI 3
`define OCC_DRIVE_LO 2
`define OCC_CAP_HI 1
`define OCC_CAP_LO 0

// =====================================================
// Hour counting limits
`define OCC_HOURS_LAST 8'h17
`define OCC_HOURS_NOON 8'h0c
`define OCC_HOURS_ZERO 8'h00

`endif

// [logic/occ_pkg.sv]
// Types shared by the oscillator control register block
package occ_pkg;

  // Decoded crystal drive strength
  typedef enum logic [1:0] {
    OCC_DRIVE_NORMAL = 2'b00,
    OCC_DRIVE_LOW = 2'b01,
    OCC_DRIVE_HIGH = 2'b10
  } occ_drive_type;

  // Decoded crystal load capacitance
  typedef enum logic [1:0] {
    OCC_CAP_7P0 = 2'b00,
    OCC_CAP_6P0 = 2'b01,
    OCC_CAP_12P5 = 2'b10
  } occ_cap_type;

endpackage : occ_pkg

// [logic/occ_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/1ps
module occ_sync
  import occ_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_sync
);

  logic stage1; // First flop, read only by the second

  // Plain two-stage shift, nothing taps stage1
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : occ_sync

// [logic/occ_link_reg.sv]
// Link-side storage of the oscillator control register
`timescale 1ns/1ps
`include "occ_cfg.svh"
module occ_link_reg
  import occ_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_resetn,
  input wire logic i_link_wr,
  input wire logic i_link_rd,
  input wire logic [7:0] i_link_addr,
  input wire logic [7:0] i_link_wdata,
  output logic [7:0] o_link_rdata,
  output logic [7:0] o_ctrl,
  output logic o_wr_toggle
);

  logic hit; // Address matches this register

  assign hit = (i_link_addr == `OCC_OSC_CTRL_ADDR);

  // =====================================================
  // Register write, all eight bits stored
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ctrl <= `OCC_OSC_CTRL_RESET;
    end else if (i_link_wr && hit) begin
      o_ctrl <= i_link_wdata;
    end
  end

  // Event toggle tells the core a new value is stable
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wr_toggle <= 1'b0;
    end else if (i_link_wr && hit) begin
      o_wr_toggle <= ~o_wr_toggle;
    end
  end

  // =====================================================
  // Read data, registered; other addresses read zero
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_link_rdata <= `OCC_RDATA_UNMAPPED;
    end else if (i_link_rd) begin
      o_link_rdata <= hit ? o_ctrl : `OCC_RDATA_UNMAPPED;
    end
  end

endmodule : occ_link_reg

// [logic/occ_core.sv]
// Oscillator control register top: link storage, crossing and field use
`timescale 1ns/1ps
`include "occ_cfg.svh"
module occ_core
  import occ_pkg::*;
(
  // Core domain, 40 MHz
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Link domain, driven by the serial management logic
  input wire logic i_link_clk,
  input wire logic i_link_wr,
  input wire logic i_link_rd,
  input wire logic [7:0] i_link_addr,
  input wire logic [7:0] i_link_wdata,
  output logic [7:0] o_link_rdata,
  // Core-domain inputs from neighbouring logic
  input wire logic i_sel_clk,
  input wire logic i_stopwatch_mode,
  input wire logic i_hour_tick,
  // Clock output stage
  output logic o_clk_out,
  output logic o_low_jitter_select_rise_en,
  output logic o_low_jitter_select_fall_en,
  // Oscillator and calibration controls
  output logic o_offset_mode_select,
  output occ_drive_type o_osc_drive_level,
  output occ_cap_type o_load_cap_select,
  // Hour counting
  output logic o_hour_12_mode,
  output logic [7:0] o_hours,
  output logic o_meridiem_indicator
);

  // =====================================================
  // Declarations

  logic [7:0] link_ctrl; // Register value in the link domain
  logic link_toggle; // Flips on every write to the register
  logic toggle_sync; // Toggle after two core flops
  logic toggle_seen; // Last toggle level already handled
  logic ctrl_update; // One-cycle pulse: new value to take
  logic [7:0] ctrl; // Core copy of the register

  logic f_invert; // Output inversion field
  logic f_offset_mode; // Calibration mode field
  logic f_hour_fmt; // 12 hour format field
  logic f_low_jitter; // Low jitter field
  logic [1:0] f_drive; // Raw drive bits
  logic [1:0] f_cap; // Raw load capacitance bits

  logic twelve_active; // 12 hour counting really in force
  logic [7:0] hour_cnt; // Internal hour count
  logic [7:0] next_hour_cnt; // Hour count after the tick
  logic [8:0] twelve_view; // Meridiem and 12 hour value

  // =====================================================
  // Decode functions

  // Drive bits to strength: both upper codes mean high
  function automatic occ_drive_type drive_decode(input logic [1:0] bits);
    occ_drive_type res;
    res = OCC_DRIVE_NORMAL;
    unique case (bits)
      2'b00: res = OCC_DRIVE_NORMAL; // Default
      2'b01: res = OCC_DRIVE_LOW; // Low ESR crystals
      2'b10,
      2'b11: res = OCC_DRIVE_HIGH; // High ESR crystals
    endcase
    return res;
  endfunction : drive_decode

  // Load bits to capacitance: both upper codes mean 12.5 pF
  function automatic occ_cap_type cap_decode(input logic [1:0] bits);
    occ_cap_type res;
    res = OCC_CAP_7P0;
    unique case (bits)
      2'b00: res = OCC_CAP_7P0; // Default, also used for 9.0 pF parts
      2'b01: res = OCC_CAP_6P0;
      2'b10,
      2'b11: res = OCC_CAP_12P5;
    endcase
    return res;
  endfunction : cap_decode

  // 0..23 to {pm, 1..12}; midnight shows as 12 AM
  function automatic logic [8:0] to_twelve(input logic [7:0] h);
    logic pm;
    logic [7:0] v;
    pm = (h >= `OCC_HOURS_NOON);
    v = pm ? (h - `OCC_HOURS_NOON) : h;
    if (v == `OCC_HOURS_ZERO) begin
      v = `OCC_HOURS_NOON;
    end
    return {pm, v};
  endfunction : to_twelve

  // =====================================================
  // Link-side register storage

  // Host logic writes and reads back here on its own clock
  occ_link_reg u_link_reg (
    .i_link_clk(i_link_clk),
    .i_resetn(i_resetn),
    .i_link_wr(i_link_wr),
    .i_link_rd(i_link_rd),
    .i_link_addr(i_link_addr),
    .i_link_wdata(i_link_wdata),
    .o_link_rdata(o_link_rdata),
    .o_ctrl(link_ctrl),
    .o_wr_toggle(link_toggle)
  );

  // =====================================================
  // Crossing into the core domain

  // Only the write event is synchronised; the word itself
  // has been stable for two core cycles when it is taken.
  occ_sync u_toggle_sync (
    .i_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async(link_toggle),
    .o_sync(toggle_sync)
  );

  // Remember the toggle level last acted upon
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      toggle_seen <= 1'b0;
    end else begin
      toggle_seen <= toggle_sync;
    end
  end

  assign ctrl_update = toggle_sync ^ toggle_seen;

  // Core copy of the register, loaded on each write event
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= `OCC_OSC_CTRL_RESET;
    end else if (ctrl_update) begin
      ctrl <= link_ctrl;
    end
  end

  // =====================================================
  // Field split

  assign f_invert = ctrl[`OCC_BIT_INVERT];
  assign f_offset_mode = ctrl[`OCC_BIT_OFFSET_MODE];
  assign f_hour_fmt = ctrl[`OCC_BIT_HOUR_FMT];
  assign f_low_jitter = ctrl[`OCC_BIT_LOW_JITTER];
  assign f_drive = ctrl[`OCC_DRIVE_HI:`OCC_DRIVE_LO];
  assign f_cap = ctrl[`OCC_CAP_HI:`OCC_CAP_LO];

  // =====================================================
  // Clock output stage

  // Chosen clock passed through or inverted, one flop late
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_clk_out <= 1'b0;
    end else begin
      o_clk_out <= i_sel_clk ^ f_invert;
    end
  end

  // Low jitter steers one edge only; inversion picks which.
  // Costs supply current, so it stays off unless asked.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_low_jitter_select_rise_en <= 1'b0;
      o_low_jitter_select_fall_en <= 1'b0;
    end else begin
      o_low_jitter_select_rise_en <= f_low_jitter && !f_invert;
      o_low_jitter_select_fall_en <= f_low_jitter && f_invert;
    end
  end

  // =====================================================
  // Oscillator and calibration controls

  // Analog trims and calibration mode, registered
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_offset_mode_select <= 1'b0;
      o_osc_drive_level <= OCC_DRIVE_NORMAL;
      o_load_cap_select <= OCC_CAP_7P0;
    end else begin
      o_offset_mode_select <= f_offset_mode;
      o_osc_drive_level <= drive_decode(f_drive);
      o_load_cap_select <= cap_decode(f_cap);
    end
  end

  // =====================================================
  // Hour format

  // Format bit counts only in calendar mode
  assign twelve_active = f_hour_fmt && !i_stopwatch_mode;

  // Format indication for the time counters
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hour_12_mode <= 1'b0;
    end else begin
      o_hour_12_mode <= twelve_active;
    end
  end

  // =====================================================
  // Hour counter

  // Calendar wraps after 23; elapsed mode runs free.
  // A count above 23 left from elapsed mode wraps to 0
  // on the first calendar tick rather than running on.
  always_comb begin
    next_hour_cnt = hour_cnt;
    if (i_stopwatch_mode) begin
      next_hour_cnt = hour_cnt + 8'h01;
    end else if (hour_cnt >= `OCC_HOURS_LAST) begin
      next_hour_cnt = `OCC_HOURS_ZERO;
    end else begin
      next_hour_cnt = hour_cnt + 8'h01;
    end
  end

  // Count held internally in 24 hour form in both hour formats; elapsed mode lets it pass 23
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hour_cnt <= `OCC_HOURS_ZERO;
    end else if (i_hour_tick) begin
      hour_cnt <= next_hour_cnt;
    end
  end

  assign twelve_view = to_twelve(hour_cnt);

  // Shown hours follow the format; switching needs no reload
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hours <= `OCC_HOURS_ZERO;
      o_meridiem_indicator <= 1'b0;
    end else if (twelve_active) begin
      o_hours <= twelve_view[7:0];
      o_meridiem_indicator <= twelve_view[8];
    end else begin
      o_hours <= hour_cnt;
      o_meridiem_indicator <= 1'b0;
    end
  end

endmodule : occ_core

// [verif/occ_core_monitor.sv]
// Checker for the oscillator control register top
`timescale 1ns/1ps
module occ_core_monitor
  import occ_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_sel_clk,
  input wire logic i_stopwatch_mode,
  input wire logic o_clk_out,
  input wire logic o_low_jitter_select_rise_en,
  input wire logic o_low_jitter_select_fall_en,
  input wire occ_drive_type o_osc_drive_level,
  input wire occ_cap_type o_load_cap_select,
  input wire logic o_hour_12_mode,
  input wire logic [7:0] o_hours,
  input wire logic o_meridiem_indicator
);
  // ==========
  // Core domain only, so one default clock and reset
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // Two settled cycles so a control change in flight is not judged
  chk_out_plain: assert property (
    o_low_jitter_select_rise_en && $past(o_low_jitter_select_rise_en) |-> o_clk_out == $past(i_sel_clk))
    else $error("clock output not passed through");
  chk_out_inverted: assert property (
    o_low_jitter_select_fall_en && $past(o_low_jitter_select_fall_en) |-> o_clk_out == !$past(i_sel_clk))
    else $error("clock output not inverted");
  chk_low_jitter_select_one_edge: assert property (!(o_low_jitter_select_rise_en && o_low_jitter_select_fall_en))
    else $error("low jitter on both edges");
  chk_drive_code: assert property (o_osc_drive_level != 2'b11)
    else $error("drive level code out of range");
  chk_cap_code: assert property (o_load_cap_select != 2'b11)
    else $error("load capacitance code out of range");
  chk_stopwatch_raw: assert property (
    i_stopwatch_mode |=> !o_hour_12_mode && !o_meridiem_indicator)
    else $error("hour format honoured in elapsed mode");
  chk_fmt_calendar: assert property (o_hour_12_mode |-> !$past(i_stopwatch_mode))
    else $error("12 hour mode during elapsed mode");
  chk_hour12_range: assert property (
    o_hour_12_mode && $past(o_hour_12_mode) |-> o_hours inside {[1:12]})
    else $error("12 hour value out of range");
  chk_merid_24h: assert property (!o_hour_12_mode |-> !o_meridiem_indicator)
    else $error("meridiem set outside 12 hour mode");
endmodule : occ_core_monitor

bind occ_core occ_core_monitor u_occ_mon (.*);

// [verif/occ_host_model.sv]
// Host model driving the link-side register port
`timescale 1ns/1ps
module occ_host_model (
  input wire logic i_link_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // ==========
  // Idle: strobes low, address and data scrambled
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h5a;
    o_wdata = 8'ha5;
  end

  // One strobe cycle; read data lands after the taking edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge i_link_clk);
    o_wr = wr;
    o_rd = !wr;
    o_addr = a;
    o_wdata = d;
    @(negedge i_link_clk);
    q = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // Released lines never show the last value
    o_addr = ~a;
    o_wdata = ~d;
  endtask : access
endmodule : occ_host_model

// [verif/occ_core_tb.sv]
// Self-checking bench for the oscillator control register top
`timescale 1ns/1ps
module occ_core_tb;
  import occ_pkg::*;
  logic i_core_clk = 0;
  logic i_link_clk = 0;
  logic i_resetn = 0;
  logic i_sel_clk = 0;
  logic i_stopwatch_mode = 0;
  logic i_hour_tick = 0;
  logic i_link_wr, i_link_rd, o_clk_out, o_low_jitter_select_rise_en, o_low_jitter_select_fall_en;
  logic o_offset_mode_select, o_hour_12_mode, o_meridiem_indicator;
  logic [7:0] i_link_addr, i_link_wdata, o_link_rdata, o_hours, q;
  occ_drive_type o_osc_drive_level;
  occ_cap_type o_load_cap_select;
  int num_errors = 0;
  int total_checks = 0;
  // Rows: written value, then {offset, drive, cap, 12h, rise, fall}
  logic [15:0] rows [8] = '{16'h0000, 16'h0528, 16'h0a50, 16'h0f50,
                            16'hd081, 16'h5082, 16'h2004, 16'hffd5};

  // ==========
  // Clocks: link clock unrelated in phase
  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  initial begin
    #1.3;
    forever #3 i_link_clk = ~i_link_clk;
  end
  always @(negedge i_core_clk) i_sel_clk <= ~i_sel_clk;

  occ_core dut (.*);
  occ_host_model host (
    .i_link_clk(i_link_clk),
    .i_rdata(o_link_rdata),
    .o_wr(i_link_wr),
    .o_rd(i_link_rd),
    .o_addr(i_link_addr),
    .o_wdata(i_link_wdata)
  );

  // ==========
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] outs();
    return {o_offset_mode_select, o_osc_drive_level, o_load_cap_select,
            o_hour_12_mode, o_low_jitter_select_rise_en, o_low_jitter_select_fall_en};
  endfunction : outs
  // Wait covers the crossing, and spaces writes well apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
    repeat (8) @(negedge i_core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge i_core_clk);
      i_hour_tick = 1'b1;
      @(negedge i_core_clk);
      i_hour_tick = 1'b0;
    end
    repeat (3) @(negedge i_core_clk);
  endtask : tick
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ==========
  // Main sequence
  initial begin
    repeat (16) @(negedge i_core_clk);
    i_resetn = 1'b1;
    rd(8'h25, 8'h00);
    chk(outs(), 8'h00);
    foreach (rows[i]) begin
      wr(8'h25, rows[i][15:8]);
      chk(outs(), rows[i][7:0]);
      rd(8'h25, rows[i][15:8]);
      @(posedge i_core_clk);
      #1;
      chk({7'h00, o_clk_out}, {7'h00, i_sel_clk ^ rows[i][15]});
    end
    // Unmapped place: write lost, read gives zero
    wr(8'h26, 8'h00);
    rd(8'h26, 8'h00);
    rd(8'h25, 8'hff);
    // Host picks 7.0 pF for a 9.0 pF crystal
    wr(8'h25, 8'h00);
    tick(23);
    chk(o_hours, 8'h17);
    tick(1);
    chk(o_hours, 8'h00);
    wr(8'h25, 8'h20);
    chk({o_meridiem_indicator, o_hours[6:0]}, 8'h0c);
    tick(12);
    chk({o_meridiem_indicator, o_hours[6:0]}, 8'h8c);
    tick(1);
    chk({o_meridiem_indicator, o_hours[6:0]}, 8'h81);
    i_stopwatch_mode = 1'b1;
    tick(1);
    chk({o_hour_12_mode, o_meridiem_indicator, o_hours[5:0]}, 8'h0e);
    i_stopwatch_mode = 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk({o_hour_12_mode, o_meridiem_indicator, o_hours[5:0]}, 8'hc2);
    // Reset in mid-run: register, fields and shown hours back to defaults
    @(negedge i_core_clk);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk(outs(), 8'h00);
    chk({o_meridiem_indicator, o_hours[6:0]}, 8'h00);
    rd(8'h25, 8'h00);
    finish_test();
  end

  // Hang guard, far beyond the few microseconds needed
  initial begin
    #100us;
    num_errors++;
    finish_test();
  end
endmodule : occ_core_tb
